/* rtl/dhfpm_pkg.sv */
package dhfpm_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_TX_SPACE = 8'h1c;
	localparam logic [7:0] IDX_RX_AVAIL = 8'h1d;
	localparam logic [7:0] IDX_TX_DATA  = 8'h1e;
	localparam logic [7:0] IDX_TX_LAST  = 8'h1f;
	localparam logic [7:0] IDX_RX_DATA  = 8'h20;
	localparam logic [7:0] IDX_CR_EN    = 8'h21;
	localparam logic [7:0] IDX_SAPI0    = 8'h22;
	localparam logic [7:0] IDX_TEI0     = 8'h23;
	localparam logic [7:0] IDX_SAPI1    = 8'h24;
	localparam logic [7:0] IDX_TEI1     = 8'h25;
	localparam logic [7:0] IDX_CTRL     = 8'h30;
	localparam int         ADDR_W       = 10;

	// Control register fields
	localparam int         CTRL_TRANSP    = 0;
	localparam int         CTRL_ALIGN_EN  = 1;
	localparam int         CTRL_DLCI0_EN  = 2;
	localparam int         CTRL_DLCI1_EN  = 3;
	localparam logic [3:0] CTRL_RESET     = 4'hc;
	localparam logic [3:0] CR_EN_RESET    = 4'h0;
	localparam logic [7:0] PATTERN_RESET  = 8'h00;
	localparam logic [7:0] SAPI_CR_MASK   = 8'h02;

	// FIFO shape; bit 8 tags end of packet or status word
	localparam int         FIFO_DEPTH = 8;
	localparam int         FIFO_W     = 9;
	localparam int         TAG_BIT    = 8;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Serial bit timing, 16 kbit/s D channel
	localparam int CLK_PERIOD_NS = 40;
	localparam int BIT_TIME_NS   = 62500;
	localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
endpackage

/* rtl/dhfpm_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface dhfpm_link_if;
	// Transmit bytes, device to transceiver
	logic       tx_valid;
	logic [7:0] tx_data;
	logic       tx_last;
	logic       tx_ready;
	// Received bits or end-of-frame status, transceiver to device
	logic       rx_valid;
	logic       rx_is_end;
	logic       rx_bit;
	logic [7:0] rx_status;
	logic       rx_ready;

	modport dev  (output tx_valid, tx_data, tx_last, input tx_ready,
		input rx_valid, rx_is_end, rx_bit, rx_status, output rx_ready);
	modport xcvr (input tx_valid, tx_data, tx_last, output tx_ready,
		output rx_valid, rx_is_end, rx_bit, rx_status, input rx_ready);
endinterface
`default_nettype wire

/* rtl/dhfpm_device.sv */
// Overview of operation
// - Transmit data write pushes non-final byte
// - Software writes packet's final byte to last-byte port
// - Last-byte write enters FIFO tagged end-of-packet
// - Both transmit ports share one FIFO
// - Receive port read returns and removes oldest entry
// - First received bit lands in bit 0
// - Compare enable includes or ignores C/R bit
// - Software writes zeros to upper enable bits
// - SAPI pattern bits 7..2 hold SAPI value
// - Transparent mode aligns on first SAPI pattern
// - Software sets SAPI extension bit 0 for 0/63
// - TEI pattern bits 7..1 hold TEI, bit 0 extension
// - Software programs C/R pattern bit per standard
// - Top bit of receive-available flags status word
`timescale 1ns/1ns
`default_nettype none
module dhfpm_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic                     in_valid_in,
	input  wire logic [WIDTH-1:0]         in_data_in,
	output logic                          in_ready_out,
	output logic                          out_valid_out,
	output logic [WIDTH-1:0]              out_data_out,
	input  wire logic                     out_ready_in,
	output logic [$clog2(DEPTH):0]        level_out
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               rd;
		logic [AW-1:0]               wr;
		logic [AW:0]                 cnt;
	} dhfpm_fifo_st_t;

	dhfpm_fifo_st_t s;
	dhfpm_fifo_st_t next_s;
	logic           push;
	logic           pop;

	// Pointer and count update
	always_comb
	begin
		next_s = s;
		push = in_valid_in && (s.cnt != FULL);
		pop = out_ready_in && (s.cnt != '0);
		if (push)
		begin
			next_s.mem[s.wr] = in_data_in;
			next_s.wr = s.wr + 1'b1;
		end
		if (pop)
			next_s.rd = s.rd + 1'b1;
		if (push && !pop)
			next_s.cnt = s.cnt + 1'b1;
		else if (pop && !push)
			next_s.cnt = s.cnt - 1'b1;
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s <= '0;
		else
			s <= next_s;
	end

	assign in_ready_out = s.cnt != FULL;
	assign out_valid_out = s.cnt != '0;
	assign out_data_out = s.mem[s.rd];
	assign level_out = s.cnt;
endmodule

module dhfpm_device (
	input  wire logic                              SYS_CLK_IN,
	input  wire logic                              RST_N_IN,
	input  wire logic [dhfpm_pkg::ADDR_W-1:0]      S_AXI_AWADDR_IN,
	input  wire logic                              S_AXI_AWVALID_IN,
	output logic                                   S_AXI_AWREADY_OUT,
	input  wire logic [31:0]                       S_AXI_WDATA_IN,
	input  wire logic [3:0]                        S_AXI_WSTRB_IN,
	input  wire logic                              S_AXI_WVALID_IN,
	output logic                                   S_AXI_WREADY_OUT,
	output logic [1:0]                             S_AXI_BRESP_OUT,
	output logic                                   S_AXI_BVALID_OUT,
	input  wire logic                              S_AXI_BREADY_IN,
	input  wire logic [dhfpm_pkg::ADDR_W-1:0]      S_AXI_ARADDR_IN,
	input  wire logic                              S_AXI_ARVALID_IN,
	output logic                                   S_AXI_ARREADY_OUT,
	output logic [31:0]                            S_AXI_RDATA_OUT,
	output logic [1:0]                             S_AXI_RRESP_OUT,
	output logic                                   S_AXI_RVALID_OUT,
	input  wire logic                              S_AXI_RREADY_IN,
	dhfpm_link_if.dev                              link
);
	typedef struct packed {
		logic       awready;
		logic       wready;
		logic       arready;
		logic       aw_hold;
		logic [7:0] aw_idx;
		logic       w_hold;
		logic [7:0] w_data;
		logic       w_ok;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [3:0] ctrl;
		logic [3:0] cr_en;
		logic [7:0] sapi0;
		logic [7:0] tei0;
		logic [7:0] sapi1;
		logic [7:0] tei1;
		logic [7:0] sh;
		logic [2:0] bit_cnt;
		logic [1:0] byte_idx;
		logic [7:0] sapi_hold;
		logic       accept;
		logic       aligned;
		logic       rx_ready;
		logic       push_v;
		logic [8:0] push_d;
		logic       second_v;
		logic [8:0] second_d;
		logic [3:0] stat_cnt;
	} dhfpm_dev_st_t;

	dhfpm_dev_st_t s;
	dhfpm_dev_st_t next_s;
	logic          tx_push;
	logic [8:0]    tx_push_d;
	logic          tx_in_ready;
	logic [3:0]    tx_level;
	logic          rx_in_ready;
	logic          rx_out_valid;
	logic [8:0]    rx_out_d;
	logic          rx_pop;
	logic [3:0]    rx_level;
	logic [7:0]    nsh;
	logic          transp;

	// Address octet compare; C/R bit only when enabled
	function automatic logic sapi_match(input logic [7:0] pat, input logic [7:0] got,
		input logic cr_en);
		logic [7:0] mask;
		mask = cr_en ? 8'hff : ~dhfpm_pkg::SAPI_CR_MASK;
		return ((pat ^ got) & mask) == 8'h00;
	endfunction

	// Bus slave, register file and receive assembly
	always_comb
	begin
		next_s = s;
		tx_push = 1'b0;
		tx_push_d = 9'h000;
		rx_pop = 1'b0;
		transp = s.ctrl[dhfpm_pkg::CTRL_TRANSP];
		nsh = {link.rx_bit, s.sh[7:1]};
		if (s.bvalid && S_AXI_BREADY_IN)
			next_s.bvalid = 1'b0;
		if (s.rvalid && S_AXI_RREADY_IN)
			next_s.rvalid = 1'b0;
		// Address and data accepted in either order
		if (s.awready && S_AXI_AWVALID_IN)
		begin
			next_s.aw_hold = 1'b1;
			next_s.aw_idx = S_AXI_AWADDR_IN[dhfpm_pkg::ADDR_W-1:2];
		end
		if (s.wready && S_AXI_WVALID_IN)
		begin
			next_s.w_hold = 1'b1;
			next_s.w_data = S_AXI_WDATA_IN[7:0];
			next_s.w_ok = S_AXI_WSTRB_IN[0];
		end
		if (next_s.aw_hold && next_s.w_hold && !s.bvalid)
		begin
			next_s.aw_hold = 1'b0;
			next_s.w_hold = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = dhfpm_pkg::RESP_OKAY;
			case (next_s.aw_idx)
				dhfpm_pkg::IDX_TX_DATA, dhfpm_pkg::IDX_TX_LAST:
				begin
					tx_push = next_s.w_ok && tx_in_ready;
					tx_push_d = {next_s.aw_idx == dhfpm_pkg::IDX_TX_LAST,
						next_s.w_data};
				end
				dhfpm_pkg::IDX_CR_EN:
					if (next_s.w_ok) next_s.cr_en = next_s.w_data[3:0];
				dhfpm_pkg::IDX_SAPI0:
					if (next_s.w_ok) next_s.sapi0 = next_s.w_data;
				dhfpm_pkg::IDX_TEI0:
					if (next_s.w_ok) next_s.tei0 = next_s.w_data;
				dhfpm_pkg::IDX_SAPI1:
					if (next_s.w_ok) next_s.sapi1 = next_s.w_data;
				dhfpm_pkg::IDX_TEI1:
					if (next_s.w_ok) next_s.tei1 = next_s.w_data;
				dhfpm_pkg::IDX_CTRL:
					if (next_s.w_ok) next_s.ctrl = next_s.w_data[3:0];
				default:
					next_s.bresp = dhfpm_pkg::RESP_SLVERR;
			endcase
		end
		// Read decode; receive port pops its entry
		if (s.arready && S_AXI_ARVALID_IN)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = dhfpm_pkg::RESP_OKAY;
			case (S_AXI_ARADDR_IN[dhfpm_pkg::ADDR_W-1:2])
				dhfpm_pkg::IDX_TX_SPACE:
					next_s.rdata = 8'(dhfpm_pkg::FIFO_DEPTH) - {4'h0, tx_level};
				dhfpm_pkg::IDX_RX_AVAIL:
					next_s.rdata = {s.stat_cnt != 4'h0, 3'h0, rx_level};
				dhfpm_pkg::IDX_RX_DATA:
				begin
					rx_pop = rx_out_valid;
					next_s.rdata = rx_out_valid ? rx_out_d[7:0] : 8'h00;
				end
				dhfpm_pkg::IDX_CR_EN: next_s.rdata = {4'h0, s.cr_en};
				dhfpm_pkg::IDX_SAPI0: next_s.rdata = s.sapi0;
				dhfpm_pkg::IDX_TEI0:  next_s.rdata = s.tei0;
				dhfpm_pkg::IDX_SAPI1: next_s.rdata = s.sapi1;
				dhfpm_pkg::IDX_TEI1:  next_s.rdata = s.tei1;
				dhfpm_pkg::IDX_CTRL:  next_s.rdata = {4'h0, s.ctrl};
				default:
				begin
					next_s.rdata = 8'h00;
					next_s.rresp = dhfpm_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Status word count follows pushes and pops
		if (s.push_v && rx_in_ready)
		begin
			next_s.push_v = s.second_v;
			next_s.push_d = s.second_d;
			next_s.second_v = 1'b0;
		end
		if ((s.push_v && rx_in_ready && s.push_d[dhfpm_pkg::TAG_BIT]) &&
			!(rx_pop && rx_out_d[dhfpm_pkg::TAG_BIT]))
			next_s.stat_cnt = s.stat_cnt + 4'h1;
		else if (!(s.push_v && rx_in_ready && s.push_d[dhfpm_pkg::TAG_BIT]) &&
			(rx_pop && rx_out_d[dhfpm_pkg::TAG_BIT]))
			next_s.stat_cnt = s.stat_cnt - 4'h1;
		// Receive item taken only while nothing is pending
		if (link.rx_valid && s.rx_ready)
		begin
			if (link.rx_is_end)
			begin
				if (transp || s.accept)
				begin
					next_s.push_v = 1'b1;
					next_s.push_d = {1'b1, link.rx_status};
				end
				next_s.bit_cnt = 3'h0;
				next_s.byte_idx = 2'h0;
				next_s.accept = 1'b0;
				next_s.aligned = 1'b0;
			end
			else if (transp && s.ctrl[dhfpm_pkg::CTRL_ALIGN_EN] && !s.aligned)
			begin
				next_s.sh = nsh;
				if (nsh == s.sapi0)
				begin
					next_s.aligned = 1'b1;
					next_s.bit_cnt = 3'h0;
				end
			end
			else
			begin
				next_s.sh = nsh;
				next_s.bit_cnt = s.bit_cnt + 3'h1;
				if (s.bit_cnt == 3'h7)
				begin
					if (transp)
					begin
						next_s.push_v = 1'b1;
						next_s.push_d = {1'b0, nsh};
					end
					else
					begin
						case (s.byte_idx)
							2'h0:
							begin
								next_s.sapi_hold = nsh;
								next_s.byte_idx = 2'h1;
							end
							2'h1:
							begin
								next_s.byte_idx = 2'h2;
								if ((s.ctrl[dhfpm_pkg::CTRL_DLCI0_EN] && nsh == s.tei0 &&
									sapi_match(s.sapi0, s.sapi_hold, s.cr_en[0])) ||
									(s.ctrl[dhfpm_pkg::CTRL_DLCI1_EN] && nsh == s.tei1 &&
									sapi_match(s.sapi1, s.sapi_hold, s.cr_en[1])))
								begin
									next_s.accept = 1'b1;
									next_s.push_v = 1'b1;
									next_s.push_d = {1'b0, s.sapi_hold};
									next_s.second_v = 1'b1;
									next_s.second_d = {1'b0, nsh};
								end
							end
							default:
								if (s.accept)
								begin
									next_s.push_v = 1'b1;
									next_s.push_d = {1'b0, nsh};
								end
						endcase
					end
				end
			end
		end
		// Ready flags registered from the next state
		next_s.rx_ready = !next_s.push_v;
		next_s.awready = !next_s.aw_hold && !next_s.bvalid;
		next_s.wready = !next_s.w_hold && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
	end

	// State register
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			s <= '0;
			s.ctrl <= dhfpm_pkg::CTRL_RESET;
			s.cr_en <= dhfpm_pkg::CR_EN_RESET;
			s.sapi0 <= dhfpm_pkg::PATTERN_RESET;
			s.tei0 <= dhfpm_pkg::PATTERN_RESET;
			s.sapi1 <= dhfpm_pkg::PATTERN_RESET;
			s.tei1 <= dhfpm_pkg::PATTERN_RESET;
		end
		else
			s <= next_s;
	end

	// Transmit FIFO, drained by the transceiver
	dhfpm_fifo #(.WIDTH(dhfpm_pkg::FIFO_W), .DEPTH(dhfpm_pkg::FIFO_DEPTH)) u_tx_fifo (
		.clk_in        (SYS_CLK_IN),
		.rst_n_in      (RST_N_IN),
		.in_valid_in   (tx_push),
		.in_data_in    (tx_push_d),
		.in_ready_out  (tx_in_ready),
		.out_valid_out (link.tx_valid),
		.out_data_out  ({link.tx_last, link.tx_data}),
		.out_ready_in  (link.tx_ready),
		.level_out     (tx_level)
	);

	// Receive FIFO, drained by register reads
	dhfpm_fifo #(.WIDTH(dhfpm_pkg::FIFO_W), .DEPTH(dhfpm_pkg::FIFO_DEPTH)) u_rx_fifo (
		.clk_in        (SYS_CLK_IN),
		.rst_n_in      (RST_N_IN),
		.in_valid_in   (s.push_v),
		.in_data_in    (s.push_d),
		.in_ready_out  (rx_in_ready),
		.out_valid_out (rx_out_valid),
		.out_data_out  (rx_out_d),
		.out_ready_in  (rx_pop),
		.level_out     (rx_level)
	);

	assign link.rx_ready = s.rx_ready;
	assign S_AXI_AWREADY_OUT = s.awready;
	assign S_AXI_WREADY_OUT = s.wready;
	assign S_AXI_BVALID_OUT = s.bvalid;
	assign S_AXI_BRESP_OUT = s.bresp;
	assign S_AXI_ARREADY_OUT = s.arready;
	assign S_AXI_RVALID_OUT = s.rvalid;
	assign S_AXI_RRESP_OUT = s.rresp;
	assign S_AXI_RDATA_OUT = {24'h000000, s.rdata};
endmodule
`default_nettype wire

/* rtl/dhfpm_xcvr.sv */
`timescale 1ns/1ns
`default_nettype none
module dhfpm_xcvr (
	input  wire logic       SYS_CLK_IN,
	input  wire logic       RST_N_IN,
	dhfpm_link_if.xcvr      link,
	output logic            TX_BIT_OUT,
	output logic            TX_BIT_STB_OUT,
	output logic            TX_FRAME_END_OUT,
	input  wire logic       RX_BIT_IN,
	input  wire logic       RX_BIT_STB_IN,
	input  wire logic       RX_END_IN,
	input  wire logic [7:0] RX_STATUS_IN,
	output logic            RX_OVERRUN_OUT
);
	localparam logic [10:0] DIV_LAST = 11'(dhfpm_pkg::BIT_CYCLES - 1);

	typedef struct packed {
		logic [10:0] s1;
		logic [10:0] s2;
		logic [1:0]  s3;
		logic        tx_ready;
		logic        busy;
		logic [7:0]  sh;
		logic        last;
		logic [2:0]  bcnt;
		logic [10:0] div;
		logic        tx_bit;
		logic        tx_stb;
		logic        tx_end;
		logic        pend_v;
		logic        pend_end;
		logic        pend_bit;
		logic [7:0]  pend_status;
		logic        overrun;
	} dhfpm_xcvr_st_t;

	dhfpm_xcvr_st_t s;
	dhfpm_xcvr_st_t next_s;
	logic           stb_rise;
	logic           end_rise;

	// Serialiser, pin synchroniser and receive handoff
	always_comb
	begin
		next_s = s;
		next_s.tx_stb = 1'b0;
		next_s.tx_end = 1'b0;
		next_s.s1 = {RX_STATUS_IN, RX_END_IN, RX_BIT_STB_IN, RX_BIT_IN};
		next_s.s2 = s.s1;
		next_s.s3 = s.s2[2:1];
		stb_rise = s.s2[1] && !s.s3[0];
		end_rise = s.s2[2] && !s.s3[1];
		if (link.tx_valid && s.tx_ready)
		begin
			next_s.busy = 1'b1;
			next_s.sh = link.tx_data;
			next_s.last = link.tx_last;
			next_s.bcnt = 3'h0;
			next_s.div = 11'h000;
		end
		else if (s.busy)
		begin
			next_s.div = s.div + 11'h001;
			if (s.div == DIV_LAST)
			begin
				next_s.div = 11'h000;
				next_s.tx_bit = s.sh[0];
				next_s.tx_stb = 1'b1;
				next_s.sh = {1'b0, s.sh[7:1]};
				next_s.bcnt = s.bcnt + 3'h1;
				if (s.bcnt == 3'h7)
				begin
					next_s.busy = 1'b0;
					next_s.tx_end = s.last;
				end
			end
		end
		next_s.tx_ready = !next_s.busy;
		// One pending item; a new event while full is lost
		if (s.pend_v && link.rx_ready)
			next_s.pend_v = 1'b0;
		if (stb_rise || end_rise)
		begin
			if (next_s.pend_v || (stb_rise && end_rise))
				next_s.overrun = 1'b1;
			if (!next_s.pend_v)
			begin
				next_s.pend_v = 1'b1;
				next_s.pend_end = !stb_rise;
				next_s.pend_bit = s.s2[0];
				next_s.pend_status = s.s2[10:3];
			end
		end
	end

	// State register
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			s <= '0;
		else
			s <= next_s;
	end

	assign link.tx_ready = s.tx_ready;
	assign link.rx_valid = s.pend_v;
	assign link.rx_is_end = s.pend_end;
	assign link.rx_bit = s.pend_bit;
	assign link.rx_status = s.pend_status;
	assign TX_BIT_OUT = s.tx_bit;
	assign TX_BIT_STB_OUT = s.tx_stb;
	assign TX_FRAME_END_OUT = s.tx_end;
	assign RX_OVERRUN_OUT = s.overrun;
endmodule
`default_nettype wire

/* bench/dhfpm_link_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module dhfpm_link_sva (
	input wire logic       SYS_CLK_IN,
	input wire logic       RST_N_IN,
	input wire logic       tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic       tx_last,
	input wire logic       tx_ready,
	input wire logic       rx_valid,
	input wire logic       rx_is_end,
	input wire logic       rx_bit,
	input wire logic [7:0] rx_status,
	input wire logic       rx_ready
);
	localparam int BUSY_MIN = 12490;
	localparam int BUSY_MAX = 12500;
	logic [15:0]   busy_cnt;

	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	// Cycles the transceiver has spent busy
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			busy_cnt <= 16'h0;
		else if (tx_ready)
			busy_cnt <= 16'h0;
		else
			busy_cnt <= busy_cnt + 16'h1;
	end

	// Byte handed over, then a busy stretch
	sequence tx_take;
		tx_valid && tx_ready;
	endsequence
	sequence tx_busy;
		!tx_ready [*8];
	endsequence

	tx_busy_a: assert property (tx_take |=> tx_busy)
		else $error("transceiver ready after take");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
		&& $stable(tx_last))
		else $error("fifo head changed while waiting");
	tx_len_a: assert property ($rose(tx_ready) && busy_cnt > 16'h4 |->
		busy_cnt >= BUSY_MIN && busy_cnt <= BUSY_MAX)
		else $error("byte time not eight bit periods");
	tx_bound_a: assert property (busy_cnt <= BUSY_MAX)
		else $error("transceiver busy too long");
	tx_idle_a: assert property (tx_ready && !tx_valid |=> tx_ready)
		else $error("idle transceiver dropped ready");
	rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_bit)
		&& $stable(rx_is_end) && $stable(rx_status))
		else $error("rx item changed before taken");
	rx_back_a: assert property (!rx_ready |-> ##[1:3] rx_ready)
		else $error("rx ready stuck low");
	rx_drop_a: assert property ($fell(rx_ready) |-> $past(rx_valid && rx_ready)
		|| $past(rx_valid && rx_ready, 2))
		else $error("rx ready fell without a take");
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        sys_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        tx_bit, tx_stb, tx_end, rx_bit, rx_stb, rx_end, rx_ovr;
	logic [9:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wstrb;
	logic [7:0]  rx_status;
	int          n_mismatch, cmp_count;

	dhfpm_link_if link ();
	dhfpm_device dhfpm_device_inst (.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .link(link));
	dhfpm_xcvr dhfpm_xcvr_inst (.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .link(link),
		.TX_BIT_OUT(tx_bit), .TX_BIT_STB_OUT(tx_stb), .TX_FRAME_END_OUT(tx_end),
		.RX_BIT_IN(rx_bit), .RX_BIT_STB_IN(rx_stb), .RX_END_IN(rx_end),
		.RX_STATUS_IN(rx_status), .RX_OVERRUN_OUT(rx_ovr));
	dhfpm_link_sva dhfpm_link_sva_inst (.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n),
		.tx_valid(link.tx_valid), .tx_data(link.tx_data), .tx_last(link.tx_last),
		.tx_ready(link.tx_ready), .rx_valid(link.rx_valid), .rx_is_end(link.rx_is_end),
		.rx_bit(link.rx_bit), .rx_status(link.rx_status), .rx_ready(link.rx_ready));

	// Free-running system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic timeout(input string what);
		n_mismatch++;
		$display("MISMATCH %s expected answer seen none", what);
		close_out();
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Write one register word, hold each channel until taken
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
		int   n;
		logic got;
		got = 1'b0;
		@(posedge sys_clk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && !got; n++)
		begin
			@(posedge sys_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			got = bvalid;
			r = bresp;
		end
		bready <= 1'b0;
		if (!got)
			timeout("write");
	endtask

	task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		int   n;
		logic got;
		got = 1'b0;
		@(posedge sys_clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && !got; n++)
		begin
			@(posedge sys_clk);
			if (arready)
				arvalid <= 1'b0;
			got = rvalid;
			d = rdata;
			r = rresp;
		end
		rready <= 1'b0;
		if (!got)
			timeout("read");
	endtask

	task automatic chk_rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(idx, d, r);
		check(what, d, {24'h0, exp});
		check(what, {30'h0, r}, {30'h0, dhfpm_pkg::RESP_OKAY});
	endtask

	task automatic regs_test();
		logic [31:0] d;
		logic [1:0]  r;
		chk_rd("cr_en reset", dhfpm_pkg::IDX_CR_EN, 8'h00);
		chk_rd("ctrl reset", dhfpm_pkg::IDX_CTRL, {4'h0, dhfpm_pkg::CTRL_RESET});
		axi_wr(dhfpm_pkg::IDX_CR_EN, 8'hff, r);
		chk_rd("cr_en upper", dhfpm_pkg::IDX_CR_EN, 8'h0f);
		axi_wr(dhfpm_pkg::IDX_CR_EN, 8'h00, r);
		axi_wr(dhfpm_pkg::IDX_SAPI1, 8'hfc, r);
		chk_rd("sapi1", dhfpm_pkg::IDX_SAPI1, 8'hfc);
		wstrb <= 4'h0;
		axi_wr(dhfpm_pkg::IDX_SAPI1, 8'h00, r);
		wstrb <= 4'hf;
		chk_rd("strobe off", dhfpm_pkg::IDX_SAPI1, 8'hfc);
		axi_wr(8'h3f, 8'h11, r);
		check("unmapped wr", {30'h0, r}, {30'h0, dhfpm_pkg::RESP_SLVERR});
		axi_wr(dhfpm_pkg::IDX_RX_DATA, 8'h11, r);
		check("ro wr", {30'h0, r}, {30'h0, dhfpm_pkg::RESP_SLVERR});
		axi_rd(8'h3f, d, r);
		check("unmapped rd", {30'h0, r}, {30'h0, dhfpm_pkg::RESP_SLVERR});
	endtask

	// Two bytes, second tagged; bits leave lsb first
	task automatic tx_test();
		logic [15:0] bits;
		logic [15:0] ends;
		logic [1:0]  r;
		int          n;
		axi_wr(dhfpm_pkg::IDX_TX_DATA, 8'ha5, r);
		axi_wr(dhfpm_pkg::IDX_TX_LAST, 8'h3c, r);
		for (int k = 0; k < 16; k++)
		begin
			@(posedge sys_clk);
			for (n = 0; n < 2000 && tx_stb !== 1'b1; n++)
				@(posedge sys_clk);
			if (n == 2000)
				timeout("tx bit");
			bits = {tx_bit, bits[15:1]};
			ends = {tx_end, ends[15:1]};
		end
		check("tx bits", {16'h0, bits}, 32'h3ca5);
		check("frame end", {16'h0, ends}, 32'h8000);
	endtask

	// Pin-level frame; end rises under the last strobe so it waits behind the pushes
	task automatic rx_frame(input logic [7:0] b0, input logic [7:0] b1);
		logic [15:0] w;
		w = {b1, b0};
		rx_status <= 8'h5a;
		for (int k = 0; k < 16; k++)
		begin
			@(posedge sys_clk);
			rx_bit <= w[k];
			repeat (2) @(posedge sys_clk);
			rx_stb <= 1'b1;
			repeat (2) @(posedge sys_clk);
			rx_end <= (k == 15);
			repeat (2) @(posedge sys_clk);
			rx_stb <= 1'b0;
		end
		repeat (4) @(posedge sys_clk);
		rx_end <= 1'b0;
		repeat (30) @(posedge sys_clk);
	endtask

	task automatic rx_test();
		logic [1:0] r;
		axi_wr(dhfpm_pkg::IDX_SAPI0, 8'h42, r);
		axi_wr(dhfpm_pkg::IDX_TEI0, 8'h07, r);
		rx_frame(8'h40, 8'h07);
		chk_rd("rx avail", dhfpm_pkg::IDX_RX_AVAIL, 8'h83);
		chk_rd("rx sapi", dhfpm_pkg::IDX_RX_DATA, 8'h40);
		chk_rd("rx tei", dhfpm_pkg::IDX_RX_DATA, 8'h07);
		chk_rd("rx status", dhfpm_pkg::IDX_RX_DATA, 8'h5a);
		chk_rd("rx empty", dhfpm_pkg::IDX_RX_DATA, 8'h00);
		chk_rd("avail empty", dhfpm_pkg::IDX_RX_AVAIL, 8'h00);
		axi_wr(dhfpm_pkg::IDX_CR_EN, 8'h01, r);
		rx_frame(8'h40, 8'h07);
		chk_rd("cr rejected", dhfpm_pkg::IDX_RX_AVAIL, 8'h00);
		rx_frame(8'h42, 8'h05);
		chk_rd("tei rejected", dhfpm_pkg::IDX_RX_AVAIL, 8'h00);
		rx_frame(8'h42, 8'h07);
		chk_rd("cr accepted", dhfpm_pkg::IDX_RX_AVAIL, 8'h83);
		check("overrun", {31'h0, rx_ovr}, 32'h0);
	endtask

	// Second DLCI match, then alignment search in transparent mode
	task automatic align_test();
		logic [1:0] r;
		rx_frame(8'hfe, 8'h00);
		chk_rd("dlci1 avail", dhfpm_pkg::IDX_RX_AVAIL, 8'h86);
		chk_rd("old sapi", dhfpm_pkg::IDX_RX_DATA, 8'h42);
		chk_rd("old tei", dhfpm_pkg::IDX_RX_DATA, 8'h07);
		chk_rd("old status", dhfpm_pkg::IDX_RX_DATA, 8'h5a);
		chk_rd("dlci1 sapi", dhfpm_pkg::IDX_RX_DATA, 8'hfe);
		chk_rd("dlci1 tei", dhfpm_pkg::IDX_RX_DATA, 8'h00);
		chk_rd("dlci1 status", dhfpm_pkg::IDX_RX_DATA, 8'h5a);
		axi_wr(dhfpm_pkg::IDX_SAPI0, 8'h7e, r);
		axi_wr(dhfpm_pkg::IDX_CTRL, 8'h03, r);
		rx_frame(8'h7e, 8'h3c);
		chk_rd("align avail", dhfpm_pkg::IDX_RX_AVAIL, 8'h82);
		chk_rd("align byte", dhfpm_pkg::IDX_RX_DATA, 8'h3c);
		chk_rd("align status", dhfpm_pkg::IDX_RX_DATA, 8'h5a);
	endtask

	// One byte goes to the transceiver, eight fill the fifo, one is dropped
	task automatic fill_test();
		logic [1:0] r;
		chk_rd("tx space idle", dhfpm_pkg::IDX_TX_SPACE, 8'h08);
		for (int k = 0; k < 9; k++)
			axi_wr(dhfpm_pkg::IDX_TX_DATA, 8'(k), r);
		axi_wr(dhfpm_pkg::IDX_TX_DATA, 8'hee, r);
		check("full wr", {30'h0, r}, {30'h0, dhfpm_pkg::RESP_OKAY});
		chk_rd("tx space full", dhfpm_pkg::IDX_TX_SPACE, 8'h00);
	endtask

	// Main sequence
	initial
	begin
		n_mismatch = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{rx_bit, rx_stb, rx_end} = 3'h0;
		awaddr = 10'h000;
		araddr = 10'h000;
		wdata = 32'h0;
		wstrb = 4'hf;
		rx_status = 8'h00;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		regs_test();
		rx_test();
		align_test();
		tx_test();
		fill_test();
		close_out();
	end
endmodule
`default_nettype wire
